/* design/pcsc_top.sv */
// Standard-select register bank, configuration controls and negotiation
// sequencer for a gigabit PCS. Assumes sync_ok and the partner word come
// from datapath logic on clk; MDC, MDIO, strap and config bus are async.
`timescale 1ns/1ps
`default_nettype none
`include "pcsc_defs.svh"
module pcsc_top #(
	parameter bit MDIO_EN = 1'b1,
	parameter bit STD_SWITCH = 1'b1,
	parameter bit TBI_BUILD = 1'b0,
	parameter logic [4:0] PHY_ADDR = 5'h01,
	parameter int LT_X_CYC = (`PCSC_LT_X_NS + `PCSC_CLK_NS - 1) / `PCSC_CLK_NS,
	parameter int LT_S_CYC = (`PCSC_LT_S_NS + `PCSC_CLK_NS - 1) / `PCSC_CLK_NS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic std_strap,
	input wire logic [3:0] cfg_vec,
	input wire logic mdc,
	input wire logic mdio_i,
	input wire logic sync_ok,
	input wire logic partner_cfg_valid,
	input wire logic [15:0] partner_cfg_word,
	output logic mdio_o,
	output logic mdio_oe_n,
	output logic std_sgmii,
	output logic serdes_loopback,
	output logic pma_wrap,
	output logic serdes_powerdown,
	output logic gmii_isolate,
	output logic [15:0] tx_cfg_word,
	output logic negotiation_done_irq
);
	localparam int TW = $clog2(LT_X_CYC + 1);

	logic [6:0] sync_q;
	logic mdc_s;
	logic mdc_d_r;
	logic mdio_s;
	logic strap_s;
	logic [3:0] cfg_s;
	logic rd_stb;
	logic wr_stb;
	logic [4:0] reg_addr;
	logic [15:0] wr_data;
	logic [15:0] rd_data_r;
	logic [15:0] rd_nxt;
	logic [15:0] ctrl_r;
	logic [15:0] adv_r;
	logic [15:0] lpa_r;
	logic irq_en_r;
	logic irq_st_r;
	logic std_r;
	logic strap_pend_r;
	logic an_restart_r;
	logic sync_d_r;
	logic an_std_r;
	logic an_cmp_r;
	logic [TW-1:0] lt_cnt_r;
	logic [TW-1:0] lt_lim;
	logic lt_hit;
	logic an_en;
	logic an_kick;
	logic done_pulse;
	logic loop_sel;
	logic pd_sel;
	logic iso_sel;
	logic [15:0] adv_eff;
	logic wr_std;
	logic wr_irq;
	pcsc_pkg::pcsc_an_e an_st_r;

	pcsc_sync #(
		.W(7)
	) u_sync (
		.clk(clk),
		.ce(ce),
		.d({cfg_vec, std_strap, mdio_i, mdc}),
		.q(sync_q)
	);
	assign mdc_s = sync_q[0];
	assign mdio_s = sync_q[1];
	assign strap_s = sync_q[2];
	assign cfg_s = sync_q[6:3];

	// MDC edge detect on the synchronised copy only
	always_ff @(posedge clk) begin
		if (sys_rst)
			mdc_d_r <= 1'b0;
		else if (ce)
			mdc_d_r <= mdc_s;
	end

	pcsc_mdio #(
		.PHY_ADDR(PHY_ADDR)
	) u_mdio (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce && MDIO_EN),
		.mdc_rise(mdc_s && !mdc_d_r),
		.mdio_i(mdio_s),
		.rd_data(rd_data_r),
		.mdio_o(mdio_o),
		.mdio_oe_n(mdio_oe_n),
		.rd_stb(rd_stb),
		.wr_stb(wr_stb),
		.reg_addr(reg_addr),
		.wr_data(wr_data)
	);

	assign wr_std = wr_stb && reg_addr == `PCSC_REG_STD && STD_SWITCH;
	assign wr_irq = wr_stb && reg_addr == `PCSC_REG_IRQ;

	// strap copied once after reset
	// Strap is sampled after release because a sync reset must load a constant
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			std_r <= 1'b0;
			strap_pend_r <= 1'b1;
		end else if (ce) begin
			strap_pend_r <= 1'b0;
			if (strap_pend_r)
				std_r <= strap_s;
			else if (wr_std)
				std_r <= wr_data[0];
		end
	end

	// Control register; restart bit self-clears into a one-cycle kick
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_r <= `PCSC_CTRL_RST;
			an_restart_r <= 1'b0;
		end else if (ce) begin
			an_restart_r <= wr_stb && reg_addr == `PCSC_REG_CTRL && wr_data[`PCSC_CTRL_RSTAN];
			if (wr_stb && reg_addr == `PCSC_REG_CTRL) begin
				ctrl_r <= wr_data;
				ctrl_r[`PCSC_CTRL_RSTAN] <= 1'b0;
			end
		end
	end

	// advertisement writable
	// SGMII layout holds a fixed word here, so writes only land in 1000BASE-X
	always_ff @(posedge clk) begin
		if (sys_rst)
			adv_r <= `PCSC_ADV_RST;
		else if (ce && wr_stb && reg_addr == `PCSC_REG_ADV && !std_r)
			adv_r <= wr_data;
	end

	// Interrupt control; a completion in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_en_r <= 1'b0;
			irq_st_r <= 1'b0;
		end else if (ce) begin
			if (wr_irq)
				irq_en_r <= wr_data[`PCSC_IRQ_EN];
			if (done_pulse && irq_en_r)
				irq_st_r <= 1'b1;
			else if (wr_irq && !wr_data[`PCSC_IRQ_ST])
				irq_st_r <= 1'b0;
		end
	end

	assign an_en = MDIO_EN && ctrl_r[`PCSC_CTRL_ANEN];
	assign an_kick = an_restart_r || (sync_d_r && !sync_ok) ||
		(partner_cfg_valid && partner_cfg_word == 16'h0000 && an_st_r != pcsc_pkg::AN_SEND);
	assign lt_lim = an_std_r ? TW'(LT_S_CYC) : TW'(LT_X_CYC);
	assign lt_hit = lt_cnt_r == lt_lim;
	assign done_pulse = an_st_r == pcsc_pkg::AN_LINK && lt_hit;
	assign adv_eff = std_r ? `PCSC_SGMII_ADV : adv_r;

	// Negotiation sequencer; the link timer's standard is frozen at start so a
	// mid-cycle switch finishes on the old timer, while the sent word follows std_r at once
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			an_st_r <= pcsc_pkg::AN_OFF;
			an_std_r <= 1'b0;
			an_cmp_r <= 1'b0;
			lt_cnt_r <= '0;
			sync_d_r <= 1'b0;
		end else if (ce) begin
			sync_d_r <= sync_ok;
			lt_cnt_r <= '0;
			if (!an_en) begin
				an_st_r <= pcsc_pkg::AN_OFF;
				an_cmp_r <= 1'b0;
			end else if (an_st_r == pcsc_pkg::AN_OFF || an_kick) begin
				an_st_r <= pcsc_pkg::AN_SEND;
				// The start right after reset takes the strap, not the stale reset value
				an_std_r <= strap_pend_r ? strap_s : std_r;
				an_cmp_r <= 1'b0;
			end else begin
				case (an_st_r)
					pcsc_pkg::AN_SEND: begin
						if (partner_cfg_valid && partner_cfg_word[`PCSC_ACK_BIT])
							an_st_r <= pcsc_pkg::AN_LINK;
					end
					pcsc_pkg::AN_LINK: begin
						lt_cnt_r <= lt_cnt_r + TW'(1);
						if (lt_hit) begin
							an_st_r <= pcsc_pkg::AN_DONE;
							an_cmp_r <= 1'b1;
						end
					end
					pcsc_pkg::AN_DONE: an_cmp_r <= 1'b1;
					default: an_st_r <= pcsc_pkg::AN_OFF;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			lpa_r <= 16'h0000;
		else if (ce && an_st_r == pcsc_pkg::AN_SEND && partner_cfg_valid &&
			partner_cfg_word != 16'h0000)
			lpa_r <= partner_cfg_word;
	end

	// send advertisement
	// Acknowledge is raised once a partner word has been taken
	always_ff @(posedge clk) begin
		if (sys_rst)
			tx_cfg_word <= 16'h0000;
		else if (ce) begin
			tx_cfg_word <= 16'h0000;
			if (an_st_r != pcsc_pkg::AN_OFF) begin
				tx_cfg_word <= adv_eff;
				tx_cfg_word[`PCSC_ACK_BIT] <= an_st_r != pcsc_pkg::AN_SEND || lpa_r != 16'h0000;
			end
		end
	end

	assign loop_sel = MDIO_EN ? ctrl_r[`PCSC_CTRL_LOOP] : cfg_s[`PCSC_CFG_LOOP];
	assign pd_sel = MDIO_EN ? ctrl_r[`PCSC_CTRL_PD] : cfg_s[`PCSC_CFG_PD];
	assign iso_sel = MDIO_EN ? ctrl_r[`PCSC_CTRL_ISO] : cfg_s[`PCSC_CFG_ISO];

	// Physical control outputs, each from its own flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			serdes_loopback <= 1'b0;
			pma_wrap <= 1'b0;
			serdes_powerdown <= 1'b0;
			gmii_isolate <= 1'b0;
			std_sgmii <= 1'b0;
			negotiation_done_irq <= 1'b0;
		end else if (ce) begin
			serdes_loopback <= !TBI_BUILD && loop_sel;
			pma_wrap <= TBI_BUILD && loop_sel;
			if (!TBI_BUILD && pd_sel)
				serdes_powerdown <= 1'b1;
			gmii_isolate <= iso_sel;
			std_sgmii <= std_r;
			negotiation_done_irq <= irq_en_r && irq_st_r;
		end
	end

	always_comb begin
		rd_nxt = 16'h0000;
		case (reg_addr)
			`PCSC_REG_CTRL: rd_nxt = ctrl_r;
			`PCSC_REG_STAT: begin
				rd_nxt = `PCSC_STAT_FIXED;
				rd_nxt[`PCSC_STAT_ANC] = an_cmp_r;
				rd_nxt[`PCSC_STAT_LINK] = sync_ok && (an_cmp_r || !an_en);
			end
			`PCSC_REG_ADV: rd_nxt = adv_eff;
			`PCSC_REG_LPA: rd_nxt = lpa_r;
			`PCSC_REG_EXT: rd_nxt = `PCSC_EXT_FIXED;
			`PCSC_REG_IRQ: rd_nxt = {14'h0000, irq_st_r, irq_en_r};
			`PCSC_REG_STD: rd_nxt = {15'h0000, std_r && STD_SWITCH};
			default: rd_nxt = 16'h0000;
		endcase
	end

	// Read word captured on the strobe so it holds while shifted out
	always_ff @(posedge clk) begin
		if (sys_rst)
			rd_data_r <= 16'h0000;
		else if (ce && rd_stb)
			rd_data_r <= rd_nxt;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_std_upper_zero: assert property (
		ce && rd_stb && reg_addr == `PCSC_REG_STD |=> rd_data_r[15:1] == 15'h0000)
		else $error("standard register upper bits not zero");
	chk_std_write_takes: assert property (
		ce && wr_std && !strap_pend_r |=> std_r == $past(wr_data[0]) ##1 std_sgmii == std_r || !ce)
		else $error("standard write not applied");
	chk_pd_sticky: assert property (
		serdes_powerdown |=> serdes_powerdown)
		else $error("power-down left without reset");
	chk_irq_hold: assert property (
		irq_st_r && !(ce && wr_irq && !wr_data[`PCSC_IRQ_ST]) |=> irq_st_r)
		else $error("interrupt status dropped");
	chk_irq_on_done: assert property (
		ce && done_pulse && irq_en_r |=> irq_st_r ##1 (negotiation_done_irq || !ce || !irq_en_r))
		else $error("interrupt not raised on completion");
	chk_lpa_capture: assert property (
		ce && an_en && an_st_r == pcsc_pkg::AN_SEND && partner_cfg_valid &&
		partner_cfg_word != 16'h0000 |=> lpa_r == $past(partner_cfg_word))
		else $error("partner ability not captured");
	chk_sync_restart: assert property (
		ce && an_en && sync_d_r && !sync_ok |=> an_st_r == pcsc_pkg::AN_SEND)
		else $error("sync loss did not restart negotiation");
	chk_adv_sent: assert property (
		ce && an_st_r == pcsc_pkg::AN_SEND |=> tx_cfg_word[13:0] == $past(adv_eff[13:0]))
		else $error("advertisement not sent");
	chk_iso_follow: assert property (
		ce && iso_sel |=> gmii_isolate)
		else $error("isolate not applied");
	chk_wrap_tbi_only: assert property (
		pma_wrap |-> TBI_BUILD && !serdes_loopback)
		else $error("wrap driven outside ten-bit build");

	cov_an_done: cover property (done_pulse ##1 an_cmp_r);
	cov_irq_clear: cover property (irq_st_r ##1 !irq_st_r);
	cov_std_switch: cover property (wr_std ##2 std_sgmii);
endmodule
`default_nettype wire

/* design/pcsc_defs.svh */
// Register offsets, field positions, reset values and timing figures
// for the standard-select and configuration block.
// Assumes one 40 MHz clock and an MDIO register space of 32 words.
`ifndef PCSC_DEFS_SVH
`define PCSC_DEFS_SVH
`define PCSC_REG_CTRL 5'h00
`define PCSC_REG_STAT 5'h01
`define PCSC_REG_ADV 5'h04
`define PCSC_REG_LPA 5'h05
`define PCSC_REG_EXT 5'h0F
`define PCSC_REG_IRQ 5'h10
`define PCSC_REG_STD 5'h11
`define PCSC_CTRL_LOOP 14
`define PCSC_CTRL_ANEN 12
`define PCSC_CTRL_PD 11
`define PCSC_CTRL_ISO 10
`define PCSC_CTRL_RSTAN 9
`define PCSC_CTRL_RST 16'h1000
`define PCSC_STAT_ANC 5
`define PCSC_STAT_LINK 2
`define PCSC_STAT_FIXED 16'h0108
`define PCSC_EXT_FIXED 16'h8000
`define PCSC_ADV_RST 16'h0020
`define PCSC_SGMII_ADV 16'h0001
`define PCSC_ACK_BIT 14
`define PCSC_IRQ_EN 0
`define PCSC_IRQ_ST 1
`define PCSC_CFG_LOOP 1
`define PCSC_CFG_PD 2
`define PCSC_CFG_ISO 3
`define PCSC_CLK_NS 25
`define PCSC_LT_X_NS 10000000
`define PCSC_LT_S_NS 1600000
`define PCSC_MDIO_PRE 6'h20
`define PCSC_HDR_LAST 6'h0B
`define PCSC_DAT_LAST 6'h0F
`define PCSC_OP_RD 2'h2
`define PCSC_OP_WR 2'h1
`endif

/* design/pcsc_pkg.sv */
// Types shared by the standard-select block and its MDIO slave.
// Assumes the constants header is included where offsets are needed.
package pcsc_pkg;
	typedef enum logic [1:0] {AN_OFF, AN_SEND, AN_LINK, AN_DONE} pcsc_an_e;
	typedef enum logic [2:0] {MD_PRE, MD_ST, MD_HDR, MD_TA, MD_DAT} pcsc_md_e;
endpackage

/* design/pcsc_sync.sv */
// Two-stage synchroniser for a bus of independent levels.
// Assumes each bit is a slow level; no bus coherence is offered.
`timescale 1ns/1ps
`default_nettype none
module pcsc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* design/pcsc_mdio.sv */
// MDIO serial slave: frames in, register strobes out, read data shifted back.
// Assumes mdc_rise is a one-cycle pulse from a synchronised MDC, and MDC
// is slow enough that read data is ready before the next MDC rise.
`timescale 1ns/1ps
`default_nettype none
`include "pcsc_defs.svh"
module pcsc_mdio #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic mdc_rise,
	input wire logic mdio_i,
	input wire logic [15:0] rd_data,
	output logic mdio_o,
	output logic mdio_oe_n,
	output logic rd_stb,
	output logic wr_stb,
	output logic [4:0] reg_addr,
	output logic [15:0] wr_data
);
	pcsc_pkg::pcsc_md_e st_r;
	logic [5:0] cnt_r;
	logic [15:0] sh_r;
	logic rd_r;
	logic mine_r;
	logic [11:0] hdr;

	assign hdr = {sh_r[10:0], mdio_i};

	// Frame walker; outputs change after an MDC rise, master samples next rise
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= pcsc_pkg::MD_PRE;
			cnt_r <= 6'h00;
			sh_r <= 16'h0000;
			rd_r <= 1'b0;
			mine_r <= 1'b0;
			mdio_o <= 1'b1;
			mdio_oe_n <= 1'b1;
			rd_stb <= 1'b0;
			wr_stb <= 1'b0;
			reg_addr <= 5'h00;
			wr_data <= 16'h0000;
		end else if (ce) begin
			rd_stb <= 1'b0;
			wr_stb <= 1'b0;
			if (mdc_rise) begin
				case (st_r)
					pcsc_pkg::MD_PRE: begin
						if (mdio_i) begin
							if (cnt_r != `PCSC_MDIO_PRE)
								cnt_r <= cnt_r + 6'h01;
						end else if (cnt_r == `PCSC_MDIO_PRE) begin
							st_r <= pcsc_pkg::MD_ST;
						end else begin
							cnt_r <= 6'h00;
						end
					end
					pcsc_pkg::MD_ST: begin
						cnt_r <= 6'h00;
						st_r <= mdio_i ? pcsc_pkg::MD_HDR : pcsc_pkg::MD_PRE;
					end
					pcsc_pkg::MD_HDR: begin
						sh_r <= {sh_r[14:0], mdio_i};
						cnt_r <= cnt_r + 6'h01;
						if (cnt_r == `PCSC_HDR_LAST) begin
							rd_r <= hdr[11:10] == `PCSC_OP_RD;
							mine_r <= hdr[9:5] == PHY_ADDR &&
								(hdr[11:10] == `PCSC_OP_RD || hdr[11:10] == `PCSC_OP_WR);
							rd_stb <= hdr[9:5] == PHY_ADDR && hdr[11:10] == `PCSC_OP_RD;
							reg_addr <= hdr[4:0];
							st_r <= pcsc_pkg::MD_TA;
							cnt_r <= 6'h00;
						end
					end
					pcsc_pkg::MD_TA: begin
						cnt_r <= cnt_r + 6'h01;
						if (cnt_r == 6'h00 && rd_r && mine_r) begin
							mdio_o <= 1'b0;
							mdio_oe_n <= 1'b0;
						end
						if (cnt_r == 6'h01) begin
							st_r <= pcsc_pkg::MD_DAT;
							cnt_r <= 6'h00;
							if (rd_r && mine_r) begin
								mdio_o <= rd_data[15];
								sh_r <= {rd_data[14:0], 1'b0};
							end
						end
					end
					pcsc_pkg::MD_DAT: begin
						cnt_r <= cnt_r + 6'h01;
						if (rd_r) begin
							mdio_o <= sh_r[15] | mdio_oe_n;
							sh_r <= {sh_r[14:0], 1'b0};
						end else begin
							sh_r <= {sh_r[14:0], mdio_i};
						end
						if (cnt_r == `PCSC_DAT_LAST) begin
							st_r <= pcsc_pkg::MD_PRE;
							cnt_r <= 6'h00;
							mdio_o <= 1'b1;
							mdio_oe_n <= 1'b1;
							wr_stb <= mine_r && !rd_r;
							wr_data <= {sh_r[14:0], mdio_i};
						end
					end
					default: st_r <= pcsc_pkg::MD_PRE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* tb/pcsc_mdio_mgr.sv */
// Station manager model: makes MDC, sends MDIO frames, resolves the shared line.
// Assumes a pulled-up MDIO line; MDC stands low between frames.
`timescale 1ns/1ps
`default_nettype none
`include "pcsc_defs.svh"
module pcsc_mdio_mgr #(
	parameter logic [4:0] PHY = 5'h01
) (
	input wire logic clk,
	input wire logic mdio_o,
	input wire logic mdio_oe_n,
	output logic mdc,
	output logic mdio_i
);
	logic drv_en;
	logic drv_val;
	// Released line floats to the pull-up level, never the last driven value
	assign mdio_i = drv_en ? drv_val : (mdio_oe_n ? 1'b1 : mdio_o);
	initial begin
		mdc = 1'b0;
		drv_en = 1'b0;
		drv_val = 1'b1;
	end
	// One bit of 10 clk: data set with MDC low, line sampled at the MDC rise
	task automatic bit_cyc(input logic en, input logic val, output logic smp);
		@(negedge clk);
		mdc = 1'b0;
		drv_en = en;
		drv_val = val;
		repeat (5) @(negedge clk);
		smp = mdio_i;
		mdc = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	// Whole frame; the station lets go of the line from turnaround on in reads
	task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [45:0] hdr;
		logic s;
		logic wr;
		hdr = {32'hFFFFFFFF, 2'h1, op, PHY, ra};
		wr = (op == `PCSC_OP_WR);
		for (int i = 45; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
		bit_cyc(wr, 1'b1, s);
		bit_cyc(wr, 1'b0, s);
		for (int i = 15; i >= 0; i--) begin
			bit_cyc(wr, wd[i], s);
			rd[i] = s;
		end
		@(negedge clk);
		mdc = 1'b0;
		drv_en = 1'b0;
		// Lets a write land through the MDC synchroniser before the next frame
		repeat (8) @(negedge clk);
	endtask
endmodule
`default_nettype wire

/* tb/pcsc_top_tb.sv */
// Bench for the standard-select block: one MDIO build, plus serial and
// ten-bit builds without MDIO sharing one configuration bus.
// Assumes the station model and link timers shortened to 20 and 10 clk.
`timescale 1ns/1ps
`default_nettype none
`include "pcsc_defs.svh"
module pcsc_top_tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic std_strap = 1'b1;
	logic [3:0] cfg_vec = 4'h0;
	logic sync_ok = 1'b1;
	logic ce_cfg = 1'b1;
	logic partner_cfg_valid = 1'b0;
	logic [15:0] partner_cfg_word = 16'h0000;
	logic mdc;
	logic mdio_i;
	logic mdio_o;
	logic mdio_oe_n;
	logic std_sgmii;
	logic [15:0] tx_cfg_word;
	logic negotiation_done_irq;
	logic [2:0] lb, wr, pd, iso;
	logic [15:0] tx_c [1:2];
	logic irq_c [1:2];
	int error_cnt = 0;
	int tests_run = 0;
	int cyc_cnt = 0;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	pcsc_top #(.LT_X_CYC(20), .LT_S_CYC(10)) i_pcsc_top (.clk(clk), .sys_rst(sys_rst),
		.ce(1'b1), .std_strap(std_strap), .cfg_vec(cfg_vec), .mdc(mdc), .mdio_i(mdio_i),
		.sync_ok(sync_ok), .partner_cfg_valid(partner_cfg_valid),
		.partner_cfg_word(partner_cfg_word), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
		.std_sgmii(std_sgmii), .serdes_loopback(lb[0]), .pma_wrap(wr[0]),
		.serdes_powerdown(pd[0]), .gmii_isolate(iso[0]), .tx_cfg_word(tx_cfg_word),
		.negotiation_done_irq(negotiation_done_irq));
	// Builds without MDIO: k=1 serial, k=2 ten-bit
	for (genvar k = 1; k <= 2; k++) begin : g_cfg
		pcsc_top #(.MDIO_EN(1'b0), .TBI_BUILD(k == 2)) i_pcsc_top (.clk(clk),
			.sys_rst(sys_rst), .ce(ce_cfg), .std_strap(std_strap), .cfg_vec(cfg_vec), .mdc(mdc),
			.mdio_i(mdio_i), .sync_ok(sync_ok), .partner_cfg_valid(partner_cfg_valid),
			.partner_cfg_word(partner_cfg_word), .mdio_o(), .mdio_oe_n(), .std_sgmii(),
			.serdes_loopback(lb[k]), .pma_wrap(wr[k]), .serdes_powerdown(pd[k]),
			.gmii_isolate(iso[k]), .tx_cfg_word(tx_c[k]), .negotiation_done_irq(irq_c[k]));
	end
	pcsc_mdio_mgr i_pcsc_mdio_mgr (.clk(clk), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
		.mdc(mdc), .mdio_i(mdio_i));
	task automatic wrap_up();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Hang guard, well above the roughly 16000 clk the sequence needs
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 40000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] dummy;
		i_pcsc_mdio_mgr.frame(`PCSC_OP_WR, ra, d, dummy);
	endtask
	task automatic reg_rd(input logic [4:0] ra, output logic [15:0] d);
		i_pcsc_mdio_mgr.frame(`PCSC_OP_RD, ra, 16'h0000, d);
	endtask
	// One-cycle partner word; the bus is scrambled once valid drops
	task automatic send_word(input logic [15:0] w);
		@(negedge clk);
		partner_cfg_valid = 1'b1;
		partner_cfg_word = w;
		@(negedge clk);
		partner_cfg_valid = 1'b0;
		partner_cfg_word = ~w;
	endtask
	// Reset with a given strap; standard follows the strap, power-down clears
	task automatic t_reset(input logic s);
		logic [15:0] v;
		@(negedge clk);
		std_strap = s;
		sys_rst = 1'b1;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (6) @(negedge clk);
		chk(16'(std_sgmii), 16'(s));
		chk(16'({pd[0], pd[1]}), 16'h0000);
		reg_rd(`PCSC_REG_STD, v);
		chk(v, 16'(s));
	endtask
	// Standard register during negotiation: reserved bits, both layouts
	task automatic t_std_rw();
		logic [15:0] v;
		reg_wr(`PCSC_REG_STD, 16'hFFFE);
		reg_rd(`PCSC_REG_STD, v);
		chk(v, 16'h0000);
		chk(16'(std_sgmii), 16'h0000);
		reg_rd(`PCSC_REG_ADV, v);
		chk(v, `PCSC_ADV_RST);
		reg_wr(`PCSC_REG_STD, 16'h0001);
		reg_rd(`PCSC_REG_STD, v);
		chk(v, 16'h0001);
		chk(16'(std_sgmii), 16'h0001);
		reg_rd(`PCSC_REG_ADV, v);
		chk(v, `PCSC_SGMII_ADV);
		reg_wr(`PCSC_REG_STD, 16'h0000);
	endtask
	// Full 1000BASE-X exchange with interrupt, host polls then reads abilities
	task automatic t_neg();
		logic [15:0] v;
		reg_wr(`PCSC_REG_ADV, 16'h01A0);
		reg_rd(`PCSC_REG_ADV, v);
		chk(v, 16'h01A0);
		reg_wr(`PCSC_REG_IRQ, 16'h0001);
		reg_wr(`PCSC_REG_CTRL, `PCSC_CTRL_RST | 16'h0200);
		chk(tx_cfg_word, 16'h01A0);
		chk(16'(negotiation_done_irq), 16'h0000);
		send_word(16'h0021);
		repeat (3) @(negedge clk);
		chk(tx_cfg_word, 16'h41A0);
		reg_rd(`PCSC_REG_LPA, v);
		chk(v, 16'h0021);
		reg_rd(`PCSC_REG_STAT, v);
		chk(v & 16'h0020, 16'h0000);
		send_word(16'h4021);
		// Link timer of 20 clk: pin rises on the 22nd falling edge
		repeat (21) @(negedge clk);
		chk(16'(negotiation_done_irq), 16'h0000);
		@(negedge clk);
		chk(16'(negotiation_done_irq), 16'h0001);
		reg_rd(`PCSC_REG_STAT, v);
		chk(v & 16'h0020, 16'h0020);
		chk(16'(negotiation_done_irq), 16'h0001);
		reg_rd(`PCSC_REG_LPA, v);
		chk(v, 16'h4021);
		reg_wr(`PCSC_REG_IRQ, 16'h0001);
		chk(16'(negotiation_done_irq), 16'h0000);
	endtask
	// SGMII restart on sync loss, then on a partner zero word after completion
	task automatic t_restart();
		logic [15:0] v;
		reg_wr(`PCSC_REG_STD, 16'h0001);
		@(negedge clk);
		sync_ok = 1'b0;
		repeat (2) @(negedge clk);
		sync_ok = 1'b1;
		reg_rd(`PCSC_REG_STAT, v);
		chk(v & 16'h0020, 16'h0000);
		chk(tx_cfg_word, 16'h4001);
		send_word(16'h4021);
		// SGMII link timer of 10 clk: pin rises on the 12th falling edge
		repeat (11) @(negedge clk);
		chk(16'(negotiation_done_irq), 16'h0000);
		@(negedge clk);
		chk(16'(negotiation_done_irq), 16'h0001);
		reg_rd(`PCSC_REG_STAT, v);
		chk(v & 16'h0020, 16'h0020);
		send_word(16'h0000);
		reg_rd(`PCSC_REG_STAT, v);
		chk(v & 16'h0020, 16'h0000);
	endtask
	// Configuration bus, every bit; packed {loop,wrap,pd,iso} serial then ten-bit
	task automatic t_cfg();
		logic [3:0] vec_tbl [5] = '{4'h1, 4'h2, 4'h8, 4'h4, 4'h0};
		logic [7:0] exp_tbl [5] = '{8'h00, 8'h84, 8'h11, 8'h20, 8'h20};
		logic [7:0] got;
		// MDIO build takes the same controls from the control register
		reg_wr(`PCSC_REG_CTRL, 16'h5C00);
		chk(16'({lb[0], wr[0], pd[0], iso[0]}), 16'h000B);
		reg_wr(`PCSC_REG_CTRL, 16'h1000);
		chk(16'({lb[0], wr[0], pd[0], iso[0]}), 16'h0002);
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			cfg_vec = vec_tbl[i];
			repeat (6) @(negedge clk);
			got = {lb[1], wr[1], pd[1], iso[1], lb[2], wr[2], pd[2], iso[2]};
			chk(16'(got), 16'(exp_tbl[i]));
		end
		// Clock enable low freezes synchronisers and outputs alike
		@(negedge clk);
		ce_cfg = 1'b0;
		cfg_vec = 4'h8;
		repeat (6) @(negedge clk);
		got = {lb[1], wr[1], pd[1], iso[1], lb[2], wr[2], pd[2], iso[2]};
		chk(16'(got), 16'h0020);
		ce_cfg = 1'b1;
		repeat (6) @(negedge clk);
		got = {lb[1], wr[1], pd[1], iso[1], lb[2], wr[2], pd[2], iso[2]};
		chk(16'(got), 16'h0031);
		chk(tx_c[1] | tx_c[2], 16'h0000);
		chk(16'({irq_c[1], irq_c[2]}), 16'h0000);
	endtask
	initial begin
		t_reset(1'b1);
		t_std_rw();
		t_neg();
		t_restart();
		t_cfg();
		t_reset(1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
